// File: design/paalu_consts.svh
// Offsets, field positions, reset values and shift amounts of the accumulate block.
`ifndef PAALU_CONSTS_SVH
`define PAALU_CONSTS_SVH
`define PAALU_OFF_CTRL 8'h00
`define PAALU_OFF_ACC 8'h04
`define PAALU_OFF_PRODUCT_REGISTER 8'h08
`define PAALU_OFF_OPND 8'h0C
`define PAALU_OFF_CMD 8'h10
`define PAALU_OFF_STAT 8'h14
`define PAALU_OFF_ISTAT 8'h18
`define PAALU_OFF_IMASK 8'h1C
`define PAALU_CTRL_PM_LSB 0
`define PAALU_CTRL_OVM 2
`define PAALU_CTRL_SXM 3
`define PAALU_CMD_OP_LSB 0
`define PAALU_CMD_SHIFT_LSB 2
`define PAALU_CMD_PEXT 6
`define PAALU_CMD_OEXT 7
`define PAALU_CMD_SAME 8
`define PAALU_CMD_P_LSB 12
`define PAALU_CMD_D_LSB 16
`define PAALU_CMD_N_LSB 24
`define PAALU_STAT_BUSY 0
`define PAALU_STAT_CARRY 1
`define PAALU_STAT_OV 2
`define PAALU_INT_DONE 0
`define PAALU_INT_OVF 1
`define PAALU_PM_RESET 2'h0
`define PAALU_SH_PM1 1
`define PAALU_SH_PM2 4
`define PAALU_SH_PM3 6
`define PAALU_IMM_CYCLES 16'h0002
`define PAALU_SAT_POS 32'h7FFFFFFF
`define PAALU_SAT_NEG 32'h80000000
`endif

// File: design/paalu_pkg.sv
// Types of the accumulate block.
package paalu_pkg;
  typedef enum logic [1:0] {PAALU_OP_ADD_PRODUCT_TO_ACCUMULATOR, PAALU_OP_AND_MEM, PAALU_OP_AND_IMM} paalu_op_t;
  typedef enum logic {PAALU_IDLE, PAALU_RUN} paalu_state_t;
  typedef struct packed {
    paalu_state_t state;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic [1:0] pm;
    logic overflow_saturate_select;
    logic sign_extension_select;
    logic [31:0] acc;
    logic [31:0] product_register;
    logic [15:0] opnd;
    paalu_op_t op;
    logic [3:0] shift;
    logic [7:0] n;
    logic [7:0] iter;
    logic [15:0] total;
    logic [15:0] elapsed;
    logic carry;
    logic ov;
    logic [1:0] ist;
    logic [1:0] imask;
  } paalu_regs_t;
endpackage

// File: design/paalu_core.sv
// Product accumulate and logical AND datapath with APB registers.
`timescale 1ns/10ps
`include "paalu_consts.svh"
module paalu_core
  import paalu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  paalu_regs_t r;
  paalu_regs_t next_r;

  // ----------------------------------------
  // Product shift and accumulate datapath.
  // ----------------------------------------
  logic [31:0] shifted;
  logic [32:0] sum;
  logic ovf;
  logic [31:0] acc_result;
  logic [31:0] imm_val;

  always_comb
  begin
    case (r.pm)
      2'h1: shifted = r.product_register << `PAALU_SH_PM1;
      2'h2: shifted = r.product_register << `PAALU_SH_PM2;
      2'h3: shifted = $unsigned($signed(r.product_register) >>> `PAALU_SH_PM3);
      default: shifted = r.product_register;
    endcase
  end

  // The product is treated as signed whatever the extension select says.
  assign sum = {1'b0, r.acc} + {1'b0, shifted};
  assign ovf = (r.acc[31] == shifted[31]) && (sum[31] != r.acc[31]);

  always_comb
  begin
    if (ovf && r.overflow_saturate_select)
    begin
      acc_result = r.acc[31] ? `PAALU_SAT_NEG : `PAALU_SAT_POS;
    end
    else
    begin
      acc_result = sum[31:0];
    end
  end

  assign imm_val = {16'h0000, r.opnd} << r.shift;

  // ----------------------------------------
  // Cycle count of a command.
  // ----------------------------------------
  function automatic logic [15:0] paalu_cycles(input logic [31:0] cmd);
    logic [15:0] n;
    logic [15:0] p;
    logic [15:0] d;
    logic [15:0] c;
    n = {8'h00, cmd[`PAALU_CMD_N_LSB +: 8]};
    p = {12'h000, cmd[`PAALU_CMD_P_LSB +: 4]};
    d = {12'h000, cmd[`PAALU_CMD_D_LSB +: 4]};
    c = 16'h0000;
    if (n == 16'h0000)
    begin
      n = 16'h0001;
    end
    case (cmd[`PAALU_CMD_OP_LSB +: 2])
      2'h0:
      begin
        c = n + (cmd[`PAALU_CMD_PEXT] ? p : 16'h0000);
      end
      2'h1:
      begin
        c = n + (cmd[`PAALU_CMD_PEXT] ? p : 16'h0000);
        if (cmd[`PAALU_CMD_OEXT])
        begin
          c = c + 16'(n * d);
        end
        if (cmd[`PAALU_CMD_OEXT] && cmd[`PAALU_CMD_PEXT])
        begin
          c = c + 16'h0001;
        end
        if (cmd[`PAALU_CMD_SAME] && !cmd[`PAALU_CMD_OEXT] && !cmd[`PAALU_CMD_PEXT])
        begin
          c = c + 16'h0001;
        end
      end
      default:
      begin
        c = `PAALU_IMM_CYCLES + (cmd[`PAALU_CMD_PEXT] ? 16'(p << 1) : 16'h0000);
      end
    endcase
    return c;
  endfunction

  // ----------------------------------------
  // Next state.
  // ----------------------------------------
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic apply;
  logic [1:0] ist_set;
  logic [1:0] ist_clr;

  assign wr_en = psel && penable && r.pready && pwrite;
  assign rd_en = psel && penable && !r.pready && !pwrite;
  assign apply = (r.state == PAALU_RUN) && (r.iter < r.n);

  always_comb
  begin
    next_r = r;
    ist_set = 2'h0;
    ist_clr = 2'h0;
    mapped = (paddr[1:0] == 2'h0) && (paddr <= `PAALU_OFF_IMASK);
    next_r.pready = psel && penable && !r.pready;
    if (psel && penable && !r.pready)
    begin
      next_r.pslverr = !mapped;
      if (pwrite && (r.state == PAALU_RUN))
      begin
        if ((paddr == `PAALU_OFF_ACC) || (paddr == `PAALU_OFF_PRODUCT_REGISTER) ||
            (paddr == `PAALU_OFF_CMD))
        begin
          next_r.pslverr = 1'b1;
        end
      end
    end
    else
    begin
      next_r.pslverr = 1'b0;
    end
    if (rd_en)
    begin
      case (paddr)
        `PAALU_OFF_CTRL: next_r.prdata = {28'h0000000, r.sign_extension_select, r.overflow_saturate_select, r.pm};
        `PAALU_OFF_ACC: next_r.prdata = r.acc;
        `PAALU_OFF_PRODUCT_REGISTER: next_r.prdata = r.product_register;
        `PAALU_OFF_OPND: next_r.prdata = {16'h0000, r.opnd};
        `PAALU_OFF_STAT: next_r.prdata = {29'h00000000, r.ov, r.carry,
                                          r.state == PAALU_RUN};
        `PAALU_OFF_ISTAT: next_r.prdata = {30'h00000000, r.ist};
        `PAALU_OFF_IMASK: next_r.prdata = {30'h00000000, r.imask};
        default: next_r.prdata = 32'h00000000;
      endcase
    end
    else if (!psel)
    begin
      next_r.prdata = 32'h00000000;
    end
    if (wr_en && !r.pslverr)
    begin
      case (paddr)
        `PAALU_OFF_CTRL:
        begin
          next_r.pm = pwdata[`PAALU_CTRL_PM_LSB +: 2];
          next_r.overflow_saturate_select = pwdata[`PAALU_CTRL_OVM];
          next_r.sign_extension_select = pwdata[`PAALU_CTRL_SXM];
        end
        `PAALU_OFF_ACC: next_r.acc = pwdata;
        `PAALU_OFF_PRODUCT_REGISTER: next_r.product_register = pwdata;
        `PAALU_OFF_OPND: next_r.opnd = pwdata[15:0];
        `PAALU_OFF_CMD:
        begin
          next_r.state = PAALU_RUN;
          next_r.op = paalu_op_t'(pwdata[`PAALU_CMD_OP_LSB +: 2]);
          next_r.shift = pwdata[`PAALU_CMD_SHIFT_LSB +: 4];
          next_r.n = (pwdata[`PAALU_CMD_OP_LSB + 1] == 1'b1) ||
                     (pwdata[`PAALU_CMD_N_LSB +: 8] == 8'h00) ?
                     8'h01 : pwdata[`PAALU_CMD_N_LSB +: 8];
          next_r.iter = 8'h00;
          next_r.elapsed = 16'h0000;
          next_r.total = paalu_cycles(pwdata);
        end
        `PAALU_OFF_STAT: ist_clr = 2'h0;
        `PAALU_OFF_ISTAT: ist_clr = pwdata[1:0];
        `PAALU_OFF_IMASK: next_r.imask = pwdata[1:0];
        default: ist_clr = 2'h0;
      endcase
    end
    if (r.state == PAALU_RUN)
    begin
      next_r.elapsed = r.elapsed + 16'h0001;
      if (apply)
      begin
        next_r.iter = r.iter + 8'h01;
        case (r.op)
          PAALU_OP_ADD_PRODUCT_TO_ACCUMULATOR:
          begin
            next_r.acc = acc_result;
            next_r.carry = sum[32];
            if (ovf)
            begin
              next_r.ov = 1'b1;
              ist_set[`PAALU_INT_OVF] = 1'b1;
            end
          end
          PAALU_OP_AND_MEM: next_r.acc = {16'h0000, r.acc[15:0] & r.opnd};
          default: next_r.acc = r.acc & imm_val;
        endcase
      end
      if (r.elapsed + 16'h0001 >= r.total)
      begin
        next_r.state = PAALU_IDLE;
        ist_set[`PAALU_INT_DONE] = 1'b1;
      end
    end
    // Writing a one to the overflow status bit clears the overflow flag too.
    if (wr_en && !r.pslverr && (paddr == `PAALU_OFF_ISTAT) && pwdata[`PAALU_INT_OVF])
    begin
      next_r.ov = next_r.ov && ist_set[`PAALU_INT_OVF];
    end
    next_r.ist = (r.ist & ~ist_clr) | ist_set;
    next_r.irq = |(next_r.ist & next_r.imask);
  end

  // ----------------------------------------
  // State register.
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.pm <= `PAALU_PM_RESET;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;

  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic add_product_to_accumulator_go;
  assign add_product_to_accumulator_go = ce && apply && (r.op == PAALU_OP_ADD_PRODUCT_TO_ACCUMULATOR);

  property p_add_result;
    add_product_to_accumulator_go && !ovf |=> r.acc == $past(sum[31:0]);
  endproperty
  a_add_result: assert property (p_add_result) else $error("Accumulate sum wrong.");

  property p_sign_ext;
    r.pm == 2'h3 |-> shifted[31:25] == {7{r.product_register[31]}};
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("Product not sign extended.");

  property p_shift_four;
    r.pm == 2'h2 |-> shifted == {r.product_register[27:0], 4'h0};
  endproperty
  a_shift_four: assert property (p_shift_four) else $error("Left shift four wrong.");

  property p_carry;
    add_product_to_accumulator_go |=> r.carry == $past(sum[32]);
  endproperty
  a_carry: assert property (p_carry) else $error("Carry not from bit 31.");

  property p_saturate;
    add_product_to_accumulator_go && ovf && r.overflow_saturate_select |=> (r.acc == `PAALU_SAT_POS) || (r.acc == `PAALU_SAT_NEG);
  endproperty
  a_saturate: assert property (p_saturate) else $error("No saturation on overflow.");

  property p_ov_flag;
    add_product_to_accumulator_go && ovf |=> r.ov && r.ist[`PAALU_INT_OVF];
  endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("Overflow flag not set.");

  property p_and_mem;
    ce && apply && (r.op == PAALU_OP_AND_MEM) |=> r.acc[31:16] == 16'h0000;
  endproperty
  a_and_mem: assert property (p_and_mem) else $error("High half not cleared.");

  property p_and_imm;
    ce && apply && (r.op == PAALU_OP_AND_IMM) |=> (r.acc & ~$past(imm_val)) == 32'h0;
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("Immediate AND wrong.");

  property p_and_low;
    ce && apply && (r.op == PAALU_OP_AND_MEM) |=>
      r.acc[15:0] == ($past(r.acc[15:0]) & $past(r.opnd));
  endproperty
  a_and_low: assert property (p_and_low) else $error("Low half AND wrong.");

  property p_ce_hold;
    !ce |=> $stable(r);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("State moved while clock enable low.");

  property p_cycles;
    ce && (r.state == PAALU_RUN) && (next_r.state == PAALU_IDLE) |->
      (r.elapsed + 16'h0001 == r.total) && (r.iter + 8'(apply) == r.n);
  endproperty
  a_cycles: assert property (p_cycles) else $error("Cycle count mismatch.");

  property p_imm_time;
    ce && wr_en && (paddr == `PAALU_OFF_CMD) && (r.state == PAALU_IDLE) &&
      !r.pslverr && (pwdata[1:0] == 2'h2) && !pwdata[`PAALU_CMD_PEXT] |=> r.total == 16'h0002;
  endproperty
  a_imm_time: assert property (p_imm_time) else $error("Immediate AND not two cycles.");

  property p_irq;
    r.irq == |(r.ist & r.imask) || !$stable(r.ist) || !$stable(r.imask);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt output inconsistent.");

  c_overflow: cover property (add_product_to_accumulator_go && ovf && r.overflow_saturate_select);
  c_repeat: cover property (ce && apply && (r.n > 8'h02));
  c_and_imm: cover property (ce && apply && (r.op == PAALU_OP_AND_IMM));
  c_irq: cover property (r.irq);
  c_ce_hold: cover property (!ce && (r.state == PAALU_RUN));

endmodule // paalu_core

// File: tb/paalu_host.sv
// APB master model of the decoder side of the accumulate block.
`timescale 1ns/10ps
module paalu_host
(
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // Runs one transfer; err bit 1 marks a missing answer.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic [1:0] err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    err = 2'h2;
    r = 32'h00000000;
    for (k = 0; k < 20 && err[1]; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        r = prdata;
        err = {1'b0, pslverr};
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // paalu_host

// File: tb/tb_product_accumulate_alu.sv
// Self-checking bench of the product accumulate block.
`timescale 1ns/10ps
`include "paalu_consts.svh"
module tb_product_accumulate_alu
  import paalu_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic ce;
  int fail_count;
  int num_checks;
  int c0;
  int c;
  logic [31:0] fc [4] = '{32'h0, 32'h4, 32'h0, 32'h4};
  logic [31:0] fa [4] = '{32'hFFFFFFFF, 32'h7FFFFFFF, 32'h7FFFFFFF, 32'h80000000};
  logic [31:0] fb [4] = '{32'h1, 32'h1, 32'h1, 32'hFFFFFFFF};
  logic [31:0] fr [4] = '{32'h0, 32'h7FFFFFFF, 32'h80000000, 32'h80000000};
  logic [31:0] fs [4] = '{32'h2, 32'h4, 32'h4, 32'h6};
  logic [31:0] cmds [8] = '{32'h05000000, 32'h05003040, 32'h04000101, 32'h04020081,
    32'h040230C1, 32'h04003041, 32'h00000002, 32'h05003042};
  int tot [8] = '{5, 8, 5, 12, 16, 7, 2, 8};
  paalu_core uut
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq)
  );
  paalu_host h
  (
    .pclk(pclk),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic acc_x(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic [1:0] e;
    h.xfer(w, a, d, r, e);
    if (e[1] !== 1'b0)
    begin
      fail_count++;
      report_and_stop();
    end
    chk({31'h0, e[0]}, {31'h0, eerr});
    if (!w)
      chk(r, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc_x(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc_x(1'b0, a, 32'h0, exp, 1'b0);
  endtask
  task automatic waitd(output int n);
    n = 0;
    while (irq !== 1'b1)
    begin
      @(posedge pclk);
      n++;
      if (n > 300)
      begin
        fail_count++;
        report_and_stop();
      end
    end
  endtask
  task automatic go(input logic [31:0] cmd);
    wr(`PAALU_OFF_ISTAT, 32'h3);
    wr(`PAALU_OFF_CMD, cmd);
  endtask
  task automatic op(input logic [31:0] ctl, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] cmd);
    wr(`PAALU_OFF_CTRL, ctl);
    wr(`PAALU_OFF_ACC, a);
    wr(`PAALU_OFF_PRODUCT_REGISTER, b);
    wr(`PAALU_OFF_OPND, b);
    go(cmd);
    waitd(c);
  endtask
  function automatic logic [31:0] shp(input int m, input logic signed [31:0] v);
    case (m)
      1: return v <<< 1;
      2: return v <<< 4;
      3: return v >>> 6;
      default: return v;
    endcase
  endfunction
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    fail_count = 0;
    num_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PAALU_OFF_CTRL, 32'h0);
    rd(`PAALU_OFF_ACC, 32'h0);
    rd(`PAALU_OFF_STAT, 32'h0);
    wr(`PAALU_OFF_IMASK, 32'h1);
    for (int m = 0; m < 8; m++)
    begin
      op({28'h0, m[2], 1'b0, m[1:0]}, 32'h00001000, 32'hFFFFF040, 32'h01000000);
      rd(`PAALU_OFF_ACC, 32'h00001000 + shp(m % 4, 32'hFFFFF040));
    end
    for (int i = 0; i < 4; i++)
    begin
      op(fc[i], fa[i], fb[i], 32'h01000000);
      rd(`PAALU_OFF_ACC, fr[i]);
      rd(`PAALU_OFF_STAT, fs[i]);
    end
    op(32'h0, 32'h12345678, 32'h000000FF, 32'h01000001);
    rd(`PAALU_OFF_ACC, 32'h00000078);
    op(32'h0, 32'h12345678, 32'h0000FF00, 32'h01000001);
    rd(`PAALU_OFF_ACC, 32'h00005600);
    op(32'h0, 32'h12345678, 32'h000000FF, 32'h01000012);
    rd(`PAALU_OFF_ACC, 32'h00000670);
    op(32'h0, 32'h12345678, 32'h0000FFFF, 32'h0100003E);
    rd(`PAALU_OFF_ACC, 32'h12340000);
    op(32'h0, 32'h0, 32'h0, 32'h01000000);
    c0 = c;
    for (int i = 0; i < 8; i++)
    begin
      op(32'h0, 32'h0, 32'h0, cmds[i]);
      chk(c - c0, tot[i] - 1);
    end
    acc_x(1'b1, 8'h20, 32'h0, 32'h0, 1'b1);
    acc_x(1'b1, 8'h06, 32'h0, 32'h0, 1'b1);
    wr(`PAALU_OFF_ACC, 32'h00000055);
    go(32'h28000000);
    acc_x(1'b1, `PAALU_OFF_ACC, 32'h1, 32'h0, 1'b1);
    waitd(c);
    rd(`PAALU_OFF_ACC, 32'h00000055);
    wr(`PAALU_OFF_IMASK, 32'h0);
    go(32'h01000000);
    repeat (10) @(posedge pclk);
    chk(irq, 32'h0);
    rd(`PAALU_OFF_ISTAT, 32'h1);
    wr(`PAALU_OFF_IMASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    wr(`PAALU_OFF_ISTAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    go(32'h01000000);
    ce <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(irq, 32'h0);
    ce <= 1'b1;
    waitd(c);
    chk(c, c0);
    report_and_stop();
  end
endmodule // tb_product_accumulate_alu
